// [rtl/etc_pkg.sv]
// constants and types for the eight-bit timer capture unit
// Behaviour
// - three modes: timer, event, capture
// - timer counts internal clock, match irq clears
// - auto capture bit copies count to b, except in capture mode
// - auto capture unsynchronised, ff/00 may misread
// - source select halves period, divider doubles
// - event mode counts pin edge, polarity selectable
// - event mode match raises irq, clears
// - event match checked on pin falling edge
// - capture normal: fall to b, rise to a
// - capture inverted: rise to b, fall to a
// - first edge a-type: b unchanged, ff reset
// - capture edges pass noise rejection filter
// - status reports polarity and filter state
package etc_pkg;
   localparam int          CLK_HZ          = 250000000;
   localparam int          REF_HZ          = 16000000;
   localparam int          FASTEST_US      = 8;
   // cycles for fastest source period (8 us at 250 MHz)
   localparam int          FAST_CYCLES     = FASTEST_US * (CLK_HZ / 1000000);
   localparam logic [2:0]  SEL_FASTEST     = 3'h6;
   localparam int          PRE_W           = 18;
   localparam logic [7:0]  CAPB_RESET      = 8'hFF;
   localparam logic [7:0]  CNT_RESET       = 8'h00;
   localparam int          AUTO_CAP_BIT    = 6;
   localparam int          EDGE_POL_BIT    = 0;
   localparam int          FILT_W          = 4;

   typedef enum logic [1:0]
   {
      ETC_TIMER   = 2'b00,
      ETC_EVENT   = 2'b01,
      ETC_CAPTURE = 2'b10
   } etc_mode_e;

   typedef struct packed
   {
      logic          start;
      etc_mode_e     mode;
      logic [2:0]    source_clock_select;
      logic          prescaler_halve_select;
      logic [7:0]    compare_capture_reg_a;
   } etc_cfg_s;

   typedef struct packed
   {
      logic          rx_polarity_select;
      logic [FILT_W-1:0] rejectCycles;
   } etc_rxcfg_s;
endpackage : etc_pkg

// [rtl/etc_noise_filter.sv]
// noise rejection receiver for the counter input pin
`timescale 1ns/100ps
module etc_noise_filter
   import etc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              sampleEn,
   input  wire logic              rawIn,
   input  wire logic [FILT_W-1:0] rejectCycles,
   output logic                   filtOut,
   output logic                   busy
);
   logic [FILT_W-1:0] run_ff;
   logic [FILT_W-1:0] nxt_run;
   logic              out_ff;
   logic              nxt_out;

   // level must persist rejectCycles+1 samples before it passes
   always_comb
   begin
      nxt_run = run_ff;
      nxt_out = out_ff;
      if (sampleEn)
      begin
         if (rawIn == out_ff)
            nxt_run = '0;
         else if (run_ff >= rejectCycles)
         begin
            nxt_out = rawIn;
            nxt_run = '0;
         end
         else
            nxt_run = run_ff + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_ff <= '0;
         out_ff <= 1'b0;
      end
      else
      begin
         run_ff <= nxt_run;
         out_ff <= nxt_out;
      end
   end

   assign filtOut = out_ff;
   assign busy    = (run_ff != '0);
endmodule : etc_noise_filter

// [rtl/etc_timer.sv]
// eight-bit timer, event counter and capture unit
`timescale 1ns/100ps
module etc_timer
   import etc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  etc_pkg::etc_cfg_s      cfg,
   input  etc_pkg::etc_rxcfg_s    rxCfg,
   input  wire logic              autoCaptureWr,
   input  wire logic              edgePolaritySelect,
   input  wire logic              counterInputPin,
   output logic [7:0]             captureRegA,
   output logic [7:0]             captureRegB,
   output logic [7:0]             countValue,
   output logic                   counterIrq,
   output logic                   rxStatusPolarity,
   output logic                   rxStatusBusy
);
   import etc_pkg::*;

   logic [PRE_W-1:0] pre_ff;
   logic [PRE_W-1:0] nxt_pre;
   logic [7:0]       cnt_ff;
   logic [7:0]       nxt_cnt;
   logic [7:0]       capA_ff;
   logic [7:0]       nxt_capA;
   logic [7:0]       capB_ff;
   logic [7:0]       nxt_capB;
   logic             irq_ff;
   logic             nxt_irq;
   logic             armed_ff;
   logic             nxt_armed;
   logic             pinS1_ff;
   logic             pinS2_ff;
   logic             pinD_ff;
   logic             filtD_ff;
   logic             filtOut;
   logic             filtBusy;
   logic [PRE_W-1:0] period;
   logic             tick;
   logic             pinRise;
   logic             pinFall;
   logic             cntEdge;
   logic             matchEdge;
   logic             capIn;
   logic             capRise;
   logic             capFall;
   logic             bEdge;
   logic             aEdge;

   // source period: fastest times 2^(6-sel), doubled by divider
   always_comb
   begin
      period = PRE_W'(FAST_CYCLES) << (SEL_FASTEST - cfg.source_clock_select);
      if (cfg.prescaler_halve_select)
         period = period << 1;
   end

   always_comb
   begin
      nxt_pre = pre_ff + 1'b1;
      if (!cfg.start || pre_ff >= period - 1'b1)
         nxt_pre = '0;
   end
   assign tick = cfg.start && (pre_ff >= period - 1'b1);

   // pin synchroniser, then edge detection on second stage
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pinS1_ff <= 1'b0;
         pinS2_ff <= 1'b0;
         pinD_ff  <= 1'b0;
         filtD_ff <= 1'b0;
      end
      else
      begin
         pinS1_ff <= counterInputPin;
         pinS2_ff <= pinS1_ff;
         pinD_ff  <= pinS2_ff;
         filtD_ff <= capIn;
      end
   end
   assign pinRise = pinS2_ff && !pinD_ff;
   assign pinFall = !pinS2_ff && pinD_ff;
   // counting edge per polarity bit
   assign cntEdge   = edgePolaritySelect ? pinFall : pinRise;
   // match compared on falling edge only
   assign matchEdge = pinFall;

   // capture edges filtered for noise
   etc_noise_filter u_filter
   (
      .mclk         (mclk),
      .resetn       (resetn),
      .sampleEn     (1'b1),
      .rawIn        (pinS2_ff ^ rxCfg.rx_polarity_select),
      .rejectCycles (rxCfg.rejectCycles),
      .filtOut      (filtOut),
      .busy         (filtBusy)
   );
   assign capIn   = filtOut;
   assign capRise = capIn && !filtD_ff;
   assign capFall = !capIn && filtD_ff;
   // normal: fall to b, rise to a inverted swaps
   assign bEdge = edgePolaritySelect ? capRise : capFall;
   assign aEdge = edgePolaritySelect ? capFall : capRise;

   always_comb
   begin
      nxt_cnt   = cnt_ff;
      nxt_capA  = capA_ff;
      nxt_capB  = capB_ff;
      nxt_irq   = 1'b0;
      nxt_armed = armed_ff;
      if (!cfg.start)
      begin
         nxt_cnt   = CNT_RESET;
         nxt_armed = 1'b0;
      end
      else
      begin
         case (cfg.mode)
            ETC_TIMER:
            begin
               if (tick)
               begin
                  if (cnt_ff == cfg.compare_capture_reg_a)
                  begin
                     nxt_cnt = CNT_RESET;
                     nxt_irq = 1'b1;
                  end
                  else
                     nxt_cnt = cnt_ff + 1'b1;
               end
            end
            ETC_EVENT:
            begin
               if (matchEdge && cnt_ff == cfg.compare_capture_reg_a)
               begin
                  nxt_cnt = CNT_RESET;
                  nxt_irq = 1'b1;
               end
               else if (cntEdge)
                  nxt_cnt = cnt_ff + 1'b1;
            end
            ETC_CAPTURE:
            begin
               if (tick)
                  nxt_cnt = cnt_ff + 1'b1;
               if (aEdge)
               begin
                  nxt_capA  = cnt_ff;
                  nxt_cnt   = CNT_RESET;
                  nxt_irq   = 1'b1;
                  nxt_armed = 1'b1;
               end
               else if (bEdge && armed_ff)
                  nxt_capB = cnt_ff;
               else if (bEdge)
               begin
                  nxt_capB  = cnt_ff;
                  nxt_armed = 1'b1;
               end
            end
            default:
               nxt_cnt = cnt_ff;
         endcase
      end
      // live copy, not aligned to counting
      if (autoCaptureWr && cfg.mode != ETC_CAPTURE)
         nxt_capB = cnt_ff;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pre_ff   <= '0;
         cnt_ff   <= CNT_RESET;
         capA_ff  <= CNT_RESET;
         capB_ff  <= CAPB_RESET;
         irq_ff   <= 1'b0;
         armed_ff <= 1'b0;
      end
      else
      begin
         pre_ff   <= nxt_pre;
         cnt_ff   <= nxt_cnt;
         capA_ff  <= nxt_capA;
         capB_ff  <= nxt_capB;
         irq_ff   <= nxt_irq;
         armed_ff <= nxt_armed;
      end
   end

   assign captureRegA      = capA_ff;
   assign captureRegB      = capB_ff;
   assign countValue       = cnt_ff;
   assign counterIrq       = irq_ff;
   // polarity and filter state readback
   assign rxStatusPolarity = rxCfg.rx_polarity_select;
   assign rxStatusBusy     = filtBusy;
endmodule : etc_timer

// [verification/etc_timer_properties.sv]
// checker for the timer capture unit ports
`timescale 1ns/100ps
module etc_timer_properties
   import etc_pkg::*;
(
   input wire logic              mclk,
   input wire logic              resetn,
   input wire etc_pkg::etc_cfg_s cfg,
   input wire etc_pkg::etc_rxcfg_s rxCfg,
   input wire logic              autoCaptureWr,
   input wire logic              edgePolaritySelect,
   input wire logic              counterInputPin,
   input wire logic [7:0]        captureRegA,
   input wire logic [7:0]        captureRegB,
   input wire logic [7:0]        countValue,
   input wire logic              counterIrq,
   input wire logic              rxStatusPolarity,
   input wire logic              rxStatusBusy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   irq_pulse_a: assert property (counterIrq |=> !counterIrq)
      else $error("irq wider than one cycle");
   irq_clears_a: assert property (counterIrq |-> countValue == 8'h00)
      else $error("count not cleared with irq");
   stop_clear_a: assert property (!cfg.start |=> countValue == 8'h00)
      else $error("count not held clear");
   count_step_a: assert property ($changed(countValue) |->
      countValue == 8'h00 || countValue == $past(countValue) + 8'h01)
      else $error("count jumped");
   timer_match_a: assert property (cfg.mode == ETC_TIMER &&
      $rose(counterIrq) |-> $past(countValue) == cfg.compare_capture_reg_a
      || $past(countValue, 2) == cfg.compare_capture_reg_a)
      else $error("timer irq without match");
   event_fall_a: assert property (cfg.mode == ETC_EVENT &&
      $rose(counterIrq) |-> !counterInputPin)
      else $error("event irq with pin high");
   auto_cap_a: assert property (cfg.mode != ETC_CAPTURE &&
      $past(cfg.mode) != ETC_CAPTURE && !$past(autoCaptureWr) &&
      !$past(autoCaptureWr, 2) |-> $stable(captureRegB))
      else $error("b changed without request");
   cap_irq_a: assert property (cfg.mode == ETC_CAPTURE &&
      $changed(captureRegA) |-> ##[0:1] counterIrq)
      else $error("a capture without irq");
   status_pol_a: assert property
      (rxStatusPolarity == rxCfg.rx_polarity_select)
      else $error("status polarity wrong");
endmodule : etc_timer_properties

bind etc_timer etc_timer_properties u_prop (.mclk(mclk), .resetn(resetn),
   .cfg(cfg), .rxCfg(rxCfg), .autoCaptureWr(autoCaptureWr),
   .edgePolaritySelect(edgePolaritySelect),
   .counterInputPin(counterInputPin), .captureRegA(captureRegA),
   .captureRegB(captureRegB), .countValue(countValue),
   .counterIrq(counterIrq), .rxStatusPolarity(rxStatusPolarity),
   .rxStatusBusy(rxStatusBusy));

// [verification/etc_pulse_src.sv]
// pulse source model driving the counter input pin
`timescale 1ns/100ps
module etc_pulse_src
(
   input  wire logic mclk,
   output logic      pin
);
   initial pin = 1'b0;
   // hold a level for n clocks, never under four
   task automatic level(input logic v, input int n);
      @(posedge mclk);
      pin <= v;
      repeat (((n < 4) ? 4 : n) - 1) @(posedge mclk);
   endtask : level
   task automatic pulses(input int n, input int hi, input int lo);
      repeat (n)
      begin
         level(1'b1, hi);
         level(1'b0, lo);
      end
   endtask : pulses
endmodule : etc_pulse_src

// [verification/etc_timer_tb_top.sv]
// self-checking testbench for the timer capture unit
`timescale 1ns/100ps
module etc_timer_tb_top;
   import etc_pkg::*;
   etc_cfg_s   cfg;
   etc_rxcfg_s rxCfg;
   logic       mclk, resetn, autoCaptureWr, edgePolaritySelect, pol;
   logic       counterInputPin, counterIrq, rxStatusPolarity, rxStatusBusy;
   logic [7:0] captureRegA, captureRegB, countValue, expB;
   int         errCount, checked, irqs, cycles, cyc, p, i, cmp;

   etc_timer DUT (.mclk(mclk), .resetn(resetn), .cfg(cfg), .rxCfg(rxCfg),
      .autoCaptureWr(autoCaptureWr), .edgePolaritySelect(edgePolaritySelect),
      .counterInputPin(counterInputPin), .captureRegA(captureRegA),
      .captureRegB(captureRegB), .countValue(countValue),
      .counterIrq(counterIrq), .rxStatusPolarity(rxStatusPolarity),
      .rxStatusBusy(rxStatusBusy));
   etc_pulse_src src (.mclk(mclk), .pin(counterInputPin));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task give_verdict;
      $display("checks %0d errors %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   always @(posedge mclk)
   begin
      cycles++;
      if (counterIrq === 1'b1)
         irqs++;
      if (cycles == 60000)
      begin
         errCount++;
         give_verdict();
      end
   end

   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task setCfg(input logic s, input etc_mode_e m, input logic [2:0] k,
               input logic h, input logic [7:0] c);
      @(posedge mclk);
      cfg <= '{s, m, k, h, c};
   endtask : setCfg

   task waitIrq(input int lim);
      cyc = 0;
      do
      begin
         @(posedge mclk);
         #1;
         cyc++;
      end
      while (counterIrq !== 1'b1 && cyc < lim);
   endtask : waitIrq

   initial
   begin
      cfg = '0;
      rxCfg = '0;
      autoCaptureWr = 1'b0;
      edgePolaritySelect = 1'b0;
      resetn = 1'b0;
      expB = CAPB_RESET;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (i = 0; i < 2; i++)
      begin
         pol = i[0];
         setCfg(1'b0, ETC_CAPTURE, SEL_FASTEST, 1'b0, 8'h00);
         rxCfg <= '{1'b0, 4'h8}; // normal polarity, reject filter set to 8
         edgePolaritySelect <= pol;
         src.level(pol, 40);
         setCfg(1'b1, ETC_CAPTURE, SEL_FASTEST, 1'b0, 8'h00);
         irqs = 0;
         src.level(~pol, 4);
         src.level(pol, 2500);
         src.level(~pol, 30);
         chk("cap irq", irqs[7:0], 8'h01);
         chk("cap b kept", captureRegB, expB);
         chk("rx pol", {7'h00, rxStatusPolarity}, 8'h00);
         chk("rx idle", {7'h00, rxStatusBusy}, 8'h00);
         src.level(~pol, 3970);
         src.level(pol, 2000);
         src.level(~pol, 30);
         chk("cap b", captureRegB, 8'h02);
         chk("cap a", captureRegA, 8'h03);
         chk("cap irqs", irqs[7:0], 8'h02);
         expB = 8'h02;
      end
      $display("capture test done");
      setCfg(1'b0, ETC_TIMER, 3'h6, 1'b0, 8'hFF);
      for (i = 0; i < 2; i++)
      begin
         cmp = i ? 0 : 2;
         p = (FAST_CYCLES << (SEL_FASTEST - (i ? 5 : 6))) << i;
         setCfg(1'b1, ETC_TIMER, i ? 3'h5 : 3'h6, i[0], cmp[7:0]);
         waitIrq(30000);
         chk("timer period", 8'(cyc > cmp * p && cyc <= (cmp + 1) * p + 8),
             8'h01);
         chk("timer clear", countValue, 8'h00);
         setCfg(1'b0, ETC_TIMER, 3'h6, 1'b0, 8'hFF);
         repeat (3) @(posedge mclk);
         chk("stop clear", countValue, 8'h00);
      end
      setCfg(1'b1, ETC_TIMER, 3'h6, 1'b0, 8'hFF);
      for (cyc = 0; countValue !== 8'h02 && cyc < 8000; cyc++)
         @(posedge mclk);
      autoCaptureWr <= 1'b1;
      @(posedge mclk);
      autoCaptureWr <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("auto cap timer", captureRegB, 8'h02);
      $display("timer test done");
      for (i = 0; i < 2; i++)
      begin
         setCfg(1'b0, ETC_EVENT, 3'h6, 1'b0, 8'h03);
         edgePolaritySelect <= i[0];
         setCfg(1'b1, ETC_EVENT, 3'h6, 1'b0, 8'h03);
         irqs = 0;
         src.pulses(3 + i, 6, 8);
         chk("event irqs", irqs[7:0], 8'h01);
         src.pulses(1, 6, 8);
         autoCaptureWr <= 1'b1;
         @(posedge mclk);
         autoCaptureWr <= 1'b0;
         repeat (3) @(posedge mclk);
         chk("auto cap event", captureRegB, 8'h01);
      end
      $display("event test done");
      give_verdict();
   end
endmodule : etc_timer_tb_top
